// ==== scan_pkg.sv ====
// shared constants and helper functions for the linear scan link
package scan_pkg;

  // ************************************************************
  // clock and link timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50; // core clock, 20 MHz
  localparam int LINK_PERIOD_MIN_NS = 500; // fastest link clock, 2 MHz
  localparam int LINK_PERIOD_MAX_NS = 20000; // slowest link clock, 50 kHz
  // least period rounds up, longest period rounds down
  localparam int LINK_DIV_MIN = (LINK_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINK_DIV_MAX = LINK_PERIOD_MAX_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 9; // half-period counter width

  // ************************************************************
  // widths and sizes
  // ************************************************************
  localparam int PIX_W_DEF = 10; // digital stand-in for the video level
  localparam int FIFO_DEPTH_DEF = 16; // pixel words buffered at the controller
  localparam int CNT_W = 11; // slot and period counters
  localparam int HI_W = 16; // start high time request

  // ************************************************************
  // scan sequence counts (in link clock periods)
  // ************************************************************
  localparam logic [CNT_W-1:0] PIXEL_COUNT = 11'h600; // 1536 pixels
  localparam logic [CNT_W-1:0] DUMMY_SLOTS = 11'h00d; // 13 strobes before pixel 0
  localparam logic [CNT_W-1:0] START_LOW_MIN = 11'h010; // 16 periods low at least
  localparam logic [CNT_W-1:0] SCAN_LOW_CYC = 11'h610; // 1552: all slots plus margin
  localparam logic [HI_W-1:0] START_HIGH_MIN = 16'h0002; // 2 periods high at least
  localparam logic [2:0] INTEG_EXTRA = 3'h6; // integration tail after start falls

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic RST_LINK_CLK = 1'b0; // link clock idles low
  localparam logic RST_START = 1'b0; // no scan requested

  // ************************************************************
  // helpers
  // ************************************************************
  // rising edge between two registered samples
  function automatic logic rise_of(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // larger of two period counts, used for the low-time floor
  function automatic logic [CNT_W-1:0] max_cnt(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

endpackage

// ==== scan_link_if.sv ====
// pin-level link between the controller and the sensor
`timescale 1ns/10ps
interface scan_link_if #(parameter int PIX_W = scan_pkg::PIX_W_DEF);
  logic link_clk; // pixel clock, made by the controller
  logic scan_start_pulse; // scan start, high time sets integration
  logic [PIX_W-1:0] video; // pixel level, one per link period
  logic pixel_strobe; // rises when video is valid
  logic scan_done_flag; // end of scan

  modport sensor (
    input link_clk,
    input scan_start_pulse,
    output video,
    output pixel_strobe,
    output scan_done_flag
  );

  modport ctrl (
    output link_clk,
    output scan_start_pulse,
    input video,
    input pixel_strobe,
    input scan_done_flag
  );
endinterface

// ==== sensor_end.sv ====
// sensor end: internal timing generator and pixel shift-out
`timescale 1ns/10ps
module sensor_end #(
  parameter int PIX_W = scan_pkg::PIX_W_DEF // video word width
) (
  input wire logic core_clk_in, // core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic ce_in, // clock enable, freezes all state
  scan_link_if.sensor link, // pins toward the controller
  output logic [scan_pkg::CNT_W-1:0] pixel_index_out, // pixel wanted at next shift
  input wire logic [PIX_W-1:0] pixel_value_in, // light level of that pixel
  output logic integrating_out, // integration window open
  output logic scanning_out // shift-out in progress
);
  import scan_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_HOLD, S_ARMED, S_SHIFT} sensor_state_t;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic clk_s1_reg, clk_s2_reg, clk_prev_reg; // link clock samples
  logic st_s1_reg, st_s2_reg; // start pulse samples
  logic link_rise; // link clock rising edge, seen in core domain
  logic link_fall; // link clock falling edge

  // two flops per pin; only the second is read by logic
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      st_s1_reg <= 1'b0;
      st_s2_reg <= 1'b0;
    end else if (ce_in) begin
      clk_s1_reg <= link.link_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_prev_reg <= clk_s2_reg;
      st_s1_reg <= link.scan_start_pulse;
      st_s2_reg <= st_s1_reg;
    end
  end

  assign link_rise = rise_of(clk_s2_reg, clk_prev_reg);
  assign link_fall = rise_of(clk_prev_reg, clk_s2_reg);

  // ************************************************************
  // scan sequencer
  // ************************************************************
  sensor_state_t state_reg; // sequencer state
  logic [CNT_W-1:0] slot_reg; // slots presented so far
  logic [PIX_W-1:0] video_reg; // video pin value
  logic strobe_reg; // sample strobe pin value
  logic done_reg; // end-of-scan pin value
  logic last_slot; // every slot of the scan has been shown

  assign last_slot = (slot_reg == DUMMY_SLOTS + PIXEL_COUNT);

  // timing comes only from the start pin and the link clock [RL1]
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= S_IDLE;
      slot_reg <= '0;
      video_reg <= '0;
      strobe_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce_in) begin
      if (st_s2_reg) begin
        // start high restarts any scan in progress
        state_reg <= S_HOLD;
        slot_reg <= '0;
        strobe_reg <= 1'b0;
        done_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_HOLD: begin
            state_reg <= S_ARMED; // start just went low
          end
          S_ARMED, S_SHIFT: begin
            if (link_rise) begin
              // first shift on the first rise after start low [RL7]
              strobe_reg <= 1'b0;
              if (last_slot) begin
                state_reg <= S_IDLE;
                video_reg <= '0;
                done_reg <= 1'b1; // raised after the last pixel [RL14]
              end else begin
                state_reg <= S_SHIFT;
                slot_reg <= slot_reg + 11'h001; // one slot per clock [RL3]
                // dummy slots carry zero, then pixels in array order [RL12]
                video_reg <= (slot_reg >= DUMMY_SLOTS) ? pixel_value_in : '0;
              end
            end else if (link_fall && state_reg == S_SHIFT) begin
              strobe_reg <= 1'b1; // 14th strobe marks pixel 0 [RL11]
            end
          end
          S_IDLE: begin
            strobe_reg <= 1'b0; // wait for the next start
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // pixel asked of the array for the coming shift
  assign pixel_index_out = (slot_reg >= DUMMY_SLOTS) ? slot_reg - DUMMY_SLOTS : '0;

  // ************************************************************
  // integration window
  // ************************************************************
  logic integ_reg; // window open
  logic [2:0] tail_reg; // link rises since start fell

  // open while start is high, then six more link clocks [RL8]
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      integ_reg <= 1'b0;
      tail_reg <= '0;
    end else if (ce_in) begin
      if (st_s2_reg) begin
        integ_reg <= 1'b1;
        tail_reg <= '0;
      end else if (integ_reg && link_rise) begin
        tail_reg <= tail_reg + 3'h1;
        if (tail_reg + 3'h1 == INTEG_EXTRA) begin
          integ_reg <= 1'b0;
        end
      end
    end
  end

  assign link.video = video_reg;
  assign link.pixel_strobe = strobe_reg;
  assign link.scan_done_flag = done_reg;
  assign integrating_out = integ_reg;
  assign scanning_out = (state_reg == S_SHIFT);

endmodule // sensor_end

// ==== ctrl_end.sv ====
// controller end: link clock, start pulse, pixel capture and output buffer
// Function
// RL1: sensor times scans from start and clock
// RL2: link clock kept between 50 kHz, 2 MHz; DIV is not range-checked and a full buffer stops the clock
// RL3: one pixel presented per link clock
// RL4: link clock duty held near fifty percent; a full buffer holds the clock at one level and breaks it
// RL5: start held high at least two periods
// RL6: start held low at least sixteen periods
// RL7: shifting starts first rise after start low
// RL8: integration is start high plus six clocks
// RL9: high to low ratio sets integration time
// RL10: video sampled on strobe rising edge
// RL11: strobes counted from start fall; 14th first
// RL12: 1536 pixels per scan in array order
// RL13: scan cycle covers all pixels plus low time
// RL14: end-of-scan raised after the last pixel
`timescale 1ns/10ps

// ************************************************************
// pixel buffer
// ************************************************************
module scan_fifo #(
  parameter int W = 11, // word width
  parameter int DEPTH = scan_pkg::FIFO_DEPTH_DEF // words, power of two
) (
  input wire logic core_clk_in, // core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic ce_in, // clock enable
  input wire logic [W-1:0] in_data_in, // word to store
  input wire logic in_valid_in, // word offered
  output logic in_ready_out, // space left
  output logic [W-1:0] out_data_out, // oldest word
  output logic out_valid_out, // a word is held
  input wire logic out_ready_in // sink takes the word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH]; // storage flops
  logic [AW:0] wr_ptr_reg, rd_ptr_reg; // pointers with wrap bit
  logic push, pop; // accepted moves
  logic full, empty; // honest fill state

  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign push = in_valid_in && !full && ce_in;
  assign pop = out_ready_in && !empty && ce_in;

  // storage written at the write pointer
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

  // pointer updates
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];

endmodule // scan_fifo

// ************************************************************
// controller
// ************************************************************
module ctrl_end #(
  parameter int PIX_W = scan_pkg::PIX_W_DEF, // video word width
  parameter int DIV = scan_pkg::LINK_DIV_MIN, // core clocks per link period, even
  parameter int FIFO_DEPTH = scan_pkg::FIFO_DEPTH_DEF // buffered pixels
) (
  input wire logic core_clk_in, // core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic ce_in, // clock enable, freezes all state
  scan_link_if.ctrl link, // pins toward the sensor
  input wire logic run_in, // keep scanning
  input wire logic [scan_pkg::HI_W-1:0] high_cycles_in, // start high time, periods
  output logic [PIX_W-1:0] pix_data_out, // captured pixel
  output logic pix_last_out, // pixel 1535 of the scan
  output logic pix_valid_out, // pixel word offered
  input wire logic pix_ready_in, // user takes the word
  output logic scan_done_out // one-cycle pulse at end of scan
);
  import scan_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_HIGH, C_LOW} ctrl_state_t;

  // even divider only; DIV is taken as given, not held to the 50 kHz to 2 MHz range [RL2]
  localparam logic [DIV_W-1:0] HALF_M1 = DIV_W'(DIV / 2 - 1);

  // ************************************************************
  // link clock divider
  // ************************************************************
  logic [DIV_W-1:0] half_cnt_reg; // core cycles within a half period
  logic link_clk_reg; // link clock pin
  logic fifo_in_ready; // buffer has room
  logic run_div; // divider may advance
  logic link_fall_now; // this cycle drives the clock low

  // a full buffer stops the link clock: trades steady rate for no loss
  assign run_div = ce_in && fifo_in_ready;
  assign link_fall_now = run_div && (half_cnt_reg == HALF_M1) && link_clk_reg;

  // equal halves give a fifty percent duty while the buffer has room [RL4]
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      half_cnt_reg <= '0;
      link_clk_reg <= RST_LINK_CLK;
    end else if (run_div) begin
      if (half_cnt_reg == HALF_M1) begin
        half_cnt_reg <= '0;
        link_clk_reg <= ~link_clk_reg; // [RL2]
      end else begin
        half_cnt_reg <= half_cnt_reg + 9'h001;
      end
    end
  end

  // ************************************************************
  // start pulse sequencer
  // ************************************************************
  ctrl_state_t state_reg; // start phase
  logic [HI_W-1:0] hi_cnt_reg; // periods spent high
  logic [CNT_W-1:0] lo_cnt_reg; // periods spent low
  logic [HI_W-1:0] hi_target; // clamped high time
  logic [CNT_W-1:0] lo_target; // low time floor
  logic start_reg; // start pin
  logic start_fell; // start dropped this cycle

  assign hi_target = (high_cycles_in < START_HIGH_MIN) ? START_HIGH_MIN : high_cycles_in; // [RL5]
  assign lo_target = max_cnt(SCAN_LOW_CYC, START_LOW_MIN); // [RL6] [RL13]

  // start changes at a link clock fall, half a period before the sensor samples
  // the user's high time sets integration against a fixed low time [RL9]
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= C_IDLE;
      hi_cnt_reg <= '0;
      lo_cnt_reg <= '0;
      start_reg <= RST_START;
    end else if (link_fall_now) begin
      case (state_reg)
        C_IDLE: begin
          if (run_in) begin
            state_reg <= C_HIGH;
            start_reg <= 1'b1;
            hi_cnt_reg <= '0;
          end
        end
        C_HIGH: begin
          if (hi_cnt_reg + 16'h0001 >= hi_target) begin
            state_reg <= C_LOW; // [RL5]
            start_reg <= 1'b0;
            lo_cnt_reg <= '0;
          end else begin
            hi_cnt_reg <= hi_cnt_reg + 16'h0001;
          end
        end
        C_LOW: begin
          if (lo_cnt_reg + 11'h001 >= lo_target) begin
            // low long enough for every slot to come out [RL6] [RL13]
            state_reg <= run_in ? C_HIGH : C_IDLE;
            start_reg <= run_in;
            hi_cnt_reg <= '0;
          end else begin
            lo_cnt_reg <= lo_cnt_reg + 11'h001;
          end
        end
        default: begin
          state_reg <= C_IDLE;
          start_reg <= 1'b0;
        end
      endcase
    end
  end

  assign start_fell = link_fall_now && (state_reg == C_HIGH) &&
                      (hi_cnt_reg + 16'h0001 >= hi_target);

  // ************************************************************
  // pin synchronisers from the sensor
  // ************************************************************
  logic strb_s1_reg, strb_s2_reg, strb_prev_reg; // strobe samples
  logic done_s1_reg, done_s2_reg, done_prev_reg; // end-of-scan samples
  logic [PIX_W-1:0] vid_s1_reg, vid_s2_reg; // video samples, steady half a period

  // two flops per pin; only the second is read by logic
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strb_s1_reg <= 1'b0;
      strb_s2_reg <= 1'b0;
      strb_prev_reg <= 1'b0;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_prev_reg <= 1'b0;
      vid_s1_reg <= '0;
      vid_s2_reg <= '0;
    end else if (ce_in) begin
      strb_s1_reg <= link.pixel_strobe;
      strb_s2_reg <= strb_s1_reg;
      strb_prev_reg <= strb_s2_reg;
      done_s1_reg <= link.scan_done_flag;
      done_s2_reg <= done_s1_reg;
      done_prev_reg <= done_s2_reg;
      vid_s1_reg <= link.video;
      vid_s2_reg <= vid_s1_reg;
    end
  end

  // ************************************************************
  // strobe counting and capture
  // ************************************************************
  logic [CNT_W-1:0] strb_cnt_reg; // strobes since start fell
  logic strb_rise; // strobe rising edge
  logic cap_valid; // this strobe carries a pixel
  logic cap_last; // this strobe carries the final pixel
  logic scan_done_reg; // end-of-scan pulse

  assign strb_rise = ce_in && rise_of(strb_s2_reg, strb_prev_reg);
  // 14th strobe after start fall is pixel 0 [RL11]
  assign cap_valid = strb_rise && (strb_cnt_reg >= DUMMY_SLOTS) &&
                     (strb_cnt_reg < DUMMY_SLOTS + PIXEL_COUNT); // [RL12]
  assign cap_last = (strb_cnt_reg == DUMMY_SLOTS + PIXEL_COUNT - 11'h001);

  // count restarts on our own start fall [RL11]
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strb_cnt_reg <= '0;
    end else if (start_fell) begin
      strb_cnt_reg <= '0;
    end else if (strb_rise && strb_cnt_reg != DUMMY_SLOTS + PIXEL_COUNT) begin
      strb_cnt_reg <= strb_cnt_reg + 11'h001; // [RL10]
    end
  end

  // end-of-scan edge becomes a single pulse
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scan_done_reg <= 1'b0;
    end else if (ce_in) begin
      scan_done_reg <= rise_of(done_s2_reg, done_prev_reg);
    end
  end

  // video sampled as the strobe rises; divider stops before overflow [RL10]
  scan_fifo #(
    .W(PIX_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .in_data_in({cap_last, vid_s2_reg}),
    .in_valid_in(cap_valid),
    .in_ready_out(fifo_in_ready),
    .out_data_out({pix_last_out, pix_data_out}),
    .out_valid_out(pix_valid_out),
    .out_ready_in(pix_ready_in)
  );

  assign link.link_clk = link_clk_reg;
  assign link.scan_start_pulse = start_reg;
  assign scan_done_out = scan_done_reg;

endmodule // ctrl_end

// ==== scan_link_sva.sv ====
// concurrent checks on the pin link between the controller and the sensor
`timescale 1ns/10ps
module scan_link_sva
  import scan_pkg::*;
#(
  parameter int PIX_W = PIX_W_DEF, // video word width
  parameter int DIV = LINK_DIV_MIN // core clocks per link period
) (
  input wire logic core_clk_in, // core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic link_clk, // pixel clock
  input wire logic scan_start_pulse, // scan start
  input wire logic [PIX_W-1:0] video, // pixel level
  input wire logic pixel_strobe, // sample strobe
  input wire logic scan_done_flag // end of scan
);
  // ************************************************************
  // helper counters
  // ************************************************************
  localparam int LOW_CYC = SCAN_LOW_CYC; // low periods per scan
  localparam int SLOTS = DUMMY_SLOTS + PIXEL_COUNT; // strobes per scan
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [15:0] half_reg; // core cycles since link clock moved
  logic [15:0] hi_reg; // link falls while start high
  logic [15:0] lo_reg; // link falls while start low
  logic [15:0] stb_reg; // strobes since start fell
  logic low_seen_reg; // a full low phase has begun

  // starts saturated so the first edge after reset is not judged
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) half_reg <= 16'hffff;
    else if ($changed(link_clk)) half_reg <= 16'h0000;
    else if (half_reg != 16'hffff) half_reg <= half_reg + 16'h0001;
  end

  // period counts of both start phases
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) hi_reg <= 16'h0000;
    else if (!scan_start_pulse) hi_reg <= 16'h0000;
    else if ($fell(link_clk)) hi_reg <= hi_reg + 16'h0001;
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) lo_reg <= 16'h0000;
    else if (scan_start_pulse) lo_reg <= 16'h0000;
    else if ($fell(link_clk)) lo_reg <= lo_reg + 16'h0001;
  end

  // strobe count and first-fall marker
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) stb_reg <= 16'h0000;
    else if (scan_start_pulse) stb_reg <= 16'h0000;
    else if ($rose(pixel_strobe)) stb_reg <= stb_reg + 16'h0001;
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) low_seen_reg <= 1'b0;
    else if ($fell(scan_start_pulse)) low_seen_reg <= 1'b1;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_link_half_min: assert property ($changed(link_clk) |-> half_reg >= DIV/2 - 1)
    else $error("link clock half period too short");
  a_start_high_min: assert property ($fell(scan_start_pulse) |-> hi_reg >= 16'h0002)
    else $error("start high too short");
  a_start_low_len: assert property (
    $rose(scan_start_pulse) && low_seen_reg |-> lo_reg == LOW_CYC)
    else $error("start low length wrong");
  a_first_slot_time: assert property ($fell(scan_start_pulse) |->
    (!pixel_strobe)[*6] ##[1:14] $rose(pixel_strobe))
    else $error("first strobe not on time");
  a_slot_count: assert property ($rose(scan_done_flag) |-> stb_reg == SLOTS)
    else $error("strobe count per scan wrong");
  a_dummy_zero: assert property (
    $rose(pixel_strobe) && stb_reg < 16'h000d |-> video == '0)
    else $error("dummy slot carries data");
  a_video_held: assert property (pixel_strobe && $past(pixel_strobe) |-> $stable(video))
    else $error("video moved under strobe");
  a_strobe_width: assert property ($rose(pixel_strobe) |-> pixel_strobe[*4])
    else $error("strobe too narrow");
  a_done_holds: assert property (scan_done_flag && !scan_start_pulse |=> scan_done_flag)
    else $error("end of scan dropped early");

  // main scenarios reached
  c_scan_done: cover property ($rose(scan_done_flag));
  c_first_pixel: cover property ($rose(pixel_strobe) && stb_reg == 16'h000d);
  c_link_stall: cover property (half_reg == 16'h0040);
endmodule // scan_link_sva

// ==== linear_sensor_scan_readout_tb.sv ====
// self-checking bench: both link ends joined, pixel stream compared
`timescale 1ns/10ps
module linear_sensor_scan_readout_tb;
  import scan_pkg::*;
  localparam int DIV = 10; // 2 MHz link at 20 MHz core
  localparam int NPIX = 1536; // pixels per scan
  logic core_clk_in = 1'b0; // core clock
  logic rstn_in = 1'b0; // reset, active low
  logic run_in = 1'b0; // keep scanning
  logic pix_ready_in = 1'b0; // user pops
  logic [HI_W-1:0] high_cycles_in = 16'h0000; // below floor, taken as 2
  logic [PIX_W_DEF-1:0] pixel_value_in; // array lookup
  logic [PIX_W_DEF-1:0] pix_data_out; // popped word
  logic [CNT_W-1:0] pixel_index_out; // pixel the sensor wants
  logic pix_last_out, pix_valid_out, scan_done_out, integrating_out, scanning_out;
  logic [PIX_W_DEF-1:0] tbl [0:2047]; // light level per pixel
  int err_count = 0;
  int compares = 0;
  int got = 0; // words popped
  int dones = 0; // end-of-scan pulses
  int ints = 0; // integration windows seen
  int cyc = 0; // cycle count for the hang limit
  int int_len = 0; // cycles of current window
  int int_exp = 0; // start high periods of current window
  int scan_len = 0; // cycles of current shift-out
  int runs = 0; // shift-outs seen

  always #25 core_clk_in = ~core_clk_in;

  // ************************************************************
  // both ends and the checker
  // ************************************************************
  scan_link_if #(.PIX_W(PIX_W_DEF)) scan_link_if_i ();
  sensor_end #(.PIX_W(PIX_W_DEF)) sensor_end_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .ce_in(1'b1), .link(scan_link_if_i.sensor), .pixel_index_out(pixel_index_out),
    .pixel_value_in(pixel_value_in), .integrating_out(integrating_out),
    .scanning_out(scanning_out));
  ctrl_end #(.PIX_W(PIX_W_DEF), .DIV(DIV), .FIFO_DEPTH(FIFO_DEPTH_DEF)) ctrl_end_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .link(scan_link_if_i.ctrl),
    .run_in(run_in), .high_cycles_in(high_cycles_in), .pix_data_out(pix_data_out),
    .pix_last_out(pix_last_out), .pix_valid_out(pix_valid_out), .pix_ready_in(pix_ready_in),
    .scan_done_out(scan_done_out));
  scan_link_sva #(.PIX_W(PIX_W_DEF), .DIV(DIV)) scan_link_sva_i (.core_clk_in(core_clk_in),
    .rstn_in(rstn_in), .link_clk(scan_link_if_i.link_clk),
    .scan_start_pulse(scan_link_if_i.scan_start_pulse), .video(scan_link_if_i.video),
    .pixel_strobe(scan_link_if_i.pixel_strobe), .scan_done_flag(scan_link_if_i.scan_done_flag));
  // the array answers combinationally, as a real pixel mux would
  assign pixel_value_in = tbl[pixel_index_out];

  // ************************************************************
  // compare and verdict
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // model: pixels in array order, window length, hang limit
  always @(posedge core_clk_in) begin
    if (rstn_in && pix_valid_out === 1'b1 && pix_ready_in === 1'b1) begin
      check(pix_data_out, tbl[got % NPIX], "pixel");
      check(pix_last_out, (got % NPIX) == NPIX - 1, "last");
      got++;
    end
    if (scan_done_out === 1'b1) begin
      dones++;
      check(scanning_out, 1'b0, "scan at done");
    end
    if (scanning_out === 1'b1) scan_len++;
    else if (scan_len > 0) begin
      // a stalled link clock can only stretch a shift-out, never shorten it
      check(scan_len >= (DUMMY_SLOTS + NPIX) * DIV, 1'b1, "shift-out");
      runs++;
      scan_len = 0;
    end
    if (integrating_out === 1'b1) begin
      if (int_len == 0) int_exp = (high_cycles_in < 2) ? 2 : high_cycles_in;
      int_len++;
    end else if (int_len > 0) begin
      // round up: synchroniser lag moves both ends, not the span
      check((int_len + DIV - 1) / DIV, int_exp + 6, "integration");
      ints++;
      int_len = 0;
    end
    cyc++;
    if (cyc == 80000) begin
      check(32'h0000_0000, 32'h0000_0001, "timeout");
      print_verdict();
    end
  end

  // slow popping early fills the buffer and stalls the link clock
  always @(posedge core_clk_in) begin
    pix_ready_in <= (got >= 1000) || ($urandom % 16 == 0);
  end

  // ************************************************************
  // main sequence: two back-to-back scans, then stop
  // ************************************************************
  initial begin
    void'($urandom(60));
    foreach (tbl[i]) tbl[i] = 10'($urandom);
    repeat (5) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    run_in <= 1'b1;
    while (got < 1) @(posedge core_clk_in);
    high_cycles_in <= 16'(3 + $urandom % 18);
    while (got <= NPIX) @(posedge core_clk_in);
    run_in <= 1'b0;
    while (got < 2 * NPIX || dones < 2) @(posedge core_clk_in);
    repeat (2000) @(posedge core_clk_in);
    check(dones, 2, "scans");
    check(ints, 2, "windows");
    check(pix_valid_out, 1'b0, "idle");
    check(runs, 2, "shift-outs");
    check(scanning_out, 1'b0, "scan idle");
    print_verdict();
  end
endmodule // linear_sensor_scan_readout_tb
